/* pia_regs.vh */
// register map, field layout, reset values and timing for the phy access block
// Function
// - internal phy answers only at address 1; externals avoid 0, 1, 31
// - indirect command: busy bit31, read bit30, reserved 29:8, address 7:0
// - read bit 0 copies indirect data into the selected mac register
// - read bit 1 loads the selected mac register into indirect data
// - setting busy starts a mac transfer; busy clears when it completes
// - address, direction and busy are taken from one command write
// - phy command: address 15:11, index 10:6, reserved 5:2, write bit1, busy bit0
// - write bit 0 reads the selected phy register into phy data
// - write bit 1 writes phy data into the selected phy register
// - writing busy 1 starts a phy cycle; busy clears when it finishes
// - all phy command fields are taken from one write
// - identifier registers 2 and 3 show presence; internal phy at address 1
// - absent phy reads all ones in both identifier registers
// - control bit 15 resets the phy and clears itself when done
// - advertise, set enable 12 and restart 9; status bit 5 reports done
// - auto-negotiation completes within 1.5 seconds
// - 10 mbit strap disables auto-negotiation, 10 half duplex; software overrides
// - 100 mbit strap with non-negotiating partner falls back to 100 half
`ifndef PIA_REGS_VH
`define PIA_REGS_VH
`define PIA_MAC_PHY_CMD 8'h06
`define PIA_MAC_PHY_DATA 8'h07
`define PIA_MAC_DUPLEX 8'h01
`define PIA_DUPLEX_BIT 20
`define PIA_IC_BUSY 31
`define PIA_IC_RD 30
`define PIA_PC_ADDR_HI 15
`define PIA_PC_ADDR_LO 11
`define PIA_PC_IDX_HI 10
`define PIA_PC_IDX_LO 6
`define PIA_PC_WR 1
`define PIA_PC_BUSY 0
`define PIA_INT_PHY_ADDR 5'h01
`define PIA_PHY_CTRL 5'h00
`define PIA_PHY_STAT 5'h01
`define PIA_PHY_ID1 5'h02
`define PIA_PHY_ID2 5'h03
`define PIA_PHY_ADV 5'h04
`define PIA_PHY_LPA 5'h05
`define PIA_CTL_RESET 15
`define PIA_CTL_AN_EN 12
`define PIA_CTL_AN_RST 9
`define PIA_CTL_SPEED 13
`define PIA_CTL_FDX 8
`define PIA_ST_AN_DONE 5
`define PIA_ADV_RESET 16'h01E1
`define PIA_ST_RESET 16'h7809
`define PIA_RST_TIME_US 10
`define PIA_AN_TIME_MS 1500
`define PIA_CLK_MHZ 100
`endif

/* pia_phy_access.v */
// mac indirect command path, phy access pair and a modelled internal phy
`timescale 1ns/1ps
`include "pia_regs.vh"
module pia_phy_access #(
  parameter [15:0] ID1_VAL = 16'h1234, // arbitrary identity value
  parameter [15:0] ID2_VAL = 16'h5678, // arbitrary identity value
  parameter RST_CYCLES = `PIA_RST_TIME_US * `PIA_CLK_MHZ,
  parameter AN_CYCLES = `PIA_AN_TIME_MS * 1000 * `PIA_CLK_MHZ
) (
  input wire clk, // core clock
  input wire rst, // sync reset, active high
  input wire cmd_we, // host write strobe, indirect command
  input wire [31:0] cmd_wdata, // indirect command write value
  output wire [31:0] cmd_rdata, // indirect command readback
  input wire data_we, // host write strobe, indirect data
  input wire [31:0] data_wdata, // indirect data write value
  output wire [31:0] data_rdata, // indirect data readback
  input wire speed_10_strap, // speed strap, 1 selects 10 mbit
  input wire partner_can_an, // link partner negotiates
  input wire [15:0] partner_ability, // partner ability word
  output wire duplex_full // mac duplex select
);
  // ------------------------------------------------------------------
  // host side indirect pair
  // ------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MAC = 3'b010;
  localparam [2:0] ST_PHY = 3'b100;
  reg [2:0] state_ff;
  reg ic_busy_ff, ic_rd_ff;
  reg [7:0] ic_sel_ff;
  reg [31:0] idata_ff;
  reg [15:0] pc_ff; // reserved bits held zero
  reg [15:0] pdata_ff;
  reg duplex_ff;
  reg [15:0] ctl_ff, adv_ff;
  reg an_done_ff;
  reg [31:0] rst_cnt_ff, an_cnt_ff;
  reg strap_seen_ff;
  wire [4:0] p_addr = pc_ff[`PIA_PC_ADDR_HI:`PIA_PC_ADDR_LO];
  wire [4:0] p_idx = pc_ff[`PIA_PC_IDX_HI:`PIA_PC_IDX_LO];
  wire p_hit = (p_addr == `PIA_INT_PHY_ADDR);
  reg [15:0] phy_rd;
  reg [31:0] mac_rd;
  assign cmd_rdata = {ic_busy_ff, ic_rd_ff, 22'h0, ic_sel_ff};
  assign data_rdata = idata_ff;
  assign duplex_full = duplex_ff;
  // ------------------------------------------------------------------
  // read muxes
  // ------------------------------------------------------------------
  always @* begin
    phy_rd = 16'hFFFF;
    if (p_hit) begin
      case (p_idx)
        `PIA_PHY_CTRL: phy_rd = ctl_ff;
        `PIA_PHY_STAT: phy_rd = `PIA_ST_RESET |
          {10'h0, an_done_ff, 5'h0};
        `PIA_PHY_ID1: phy_rd = ID1_VAL;
        `PIA_PHY_ID2: phy_rd = ID2_VAL;
        `PIA_PHY_ADV: phy_rd = adv_ff;
        `PIA_PHY_LPA: phy_rd = partner_ability;
        default: phy_rd = 16'h0000;
      endcase
    end
  end
  always @* begin
    case (ic_sel_ff)
      `PIA_MAC_PHY_CMD: mac_rd = {16'h0, pc_ff};
      `PIA_MAC_PHY_DATA: mac_rd = {16'h0, pdata_ff};
      `PIA_MAC_DUPLEX: mac_rd = {11'h0, duplex_ff, 20'h0};
      default: mac_rd = 32'h0000_0000;
    endcase
  end
  // ------------------------------------------------------------------
  // sequencer: one cycle for the mac move, one for the phy cycle
  // ------------------------------------------------------------------
  wire reset_busy = ctl_ff[`PIA_CTL_RESET];
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      ic_busy_ff <= 1'b0;
      ic_rd_ff <= 1'b0;
      ic_sel_ff <= 8'h00;
      idata_ff <= 32'h0000_0000;
      pc_ff <= 16'h0000;
      pdata_ff <= 16'h0000;
      duplex_ff <= 1'b0;
    end else begin
      if (data_we && !ic_busy_ff)
        idata_ff <= data_wdata;
      case (state_ff)
        ST_IDLE: begin
          if (cmd_we && cmd_wdata[`PIA_IC_BUSY]) begin
            ic_busy_ff <= 1'b1;
            ic_rd_ff <= cmd_wdata[`PIA_IC_RD];
            ic_sel_ff <= cmd_wdata[7:0];
            state_ff <= ST_MAC;
          end
        end
        ST_MAC: begin
          ic_busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
          if (ic_rd_ff) begin
            idata_ff <= mac_rd;
          end else begin
            case (ic_sel_ff)
              `PIA_MAC_PHY_CMD: begin
                // reserved bits dropped; busy only starts a cycle
                pc_ff <= {idata_ff[15:6], 4'h0, idata_ff[1:0]};
                if (idata_ff[`PIA_PC_BUSY])
                  state_ff <= ST_PHY;
              end
              `PIA_MAC_PHY_DATA: pdata_ff <= idata_ff[15:0];
              `PIA_MAC_DUPLEX: duplex_ff <= idata_ff[`PIA_DUPLEX_BIT];
              default: ;
            endcase
          end
        end
        ST_PHY: begin
          if (!pc_ff[`PIA_PC_WR])
            pdata_ff <= phy_rd;
          pc_ff[`PIA_PC_BUSY] <= 1'b0;
          state_ff <= ST_IDLE;
          // indirect busy already reads low here, so a new command is legal
          if (cmd_we && cmd_wdata[`PIA_IC_BUSY]) begin
            ic_busy_ff <= 1'b1;
            ic_rd_ff <= cmd_wdata[`PIA_IC_RD];
            ic_sel_ff <= cmd_wdata[7:0];
            state_ff <= ST_MAC;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------------
  // internal phy control, reset and auto-negotiation
  // ------------------------------------------------------------------
  wire phy_wr = (state_ff == ST_PHY) && pc_ff[`PIA_PC_WR] && p_hit;
  always @(posedge clk) begin
    if (rst) begin
      ctl_ff <= 16'h0000;
      adv_ff <= `PIA_ADV_RESET;
      an_done_ff <= 1'b0;
      rst_cnt_ff <= 32'h0000_0000;
      an_cnt_ff <= 32'h0000_0000;
      strap_seen_ff <= 1'b0;
    end else begin
      if (!strap_seen_ff) begin
        // strap caught after reset release
        strap_seen_ff <= 1'b1;
        ctl_ff <= speed_10_strap ? 16'h0000 : 16'h3000;
      end else if (phy_wr && p_idx == `PIA_PHY_CTRL) begin
        ctl_ff <= pdata_ff;
        an_done_ff <= 1'b0;
        rst_cnt_ff <= 32'h0000_0000;
        an_cnt_ff <= 32'h0000_0000;
      end else if (reset_busy) begin
        if (rst_cnt_ff >= RST_CYCLES - 1) begin
          ctl_ff <= speed_10_strap ? 16'h0000 : 16'h3000;
          an_cnt_ff <= 32'h0000_0000;
        end else
          rst_cnt_ff <= rst_cnt_ff + 32'h1;
      end else if (ctl_ff[`PIA_CTL_AN_EN] && !an_done_ff) begin
        if (an_cnt_ff >= AN_CYCLES / 2) begin
          if (partner_can_an) begin
            an_done_ff <= 1'b1;
            ctl_ff[`PIA_CTL_AN_RST] <= 1'b0;
          end else begin
            // fallback to 100 half, negotiation off
            ctl_ff <= 16'h2000;
          end
        end else
          an_cnt_ff <= an_cnt_ff + 32'h1;
      end
      if (phy_wr && p_idx == `PIA_PHY_ADV)
        adv_ff <= pdata_ff;
    end
  end
endmodule // pia_phy_access

/* pia_phy_access_checker.sv */
// assertions on the indirect command and data ports
`timescale 1ns/1ps
module pia_phy_access_checker (
  input wire clk, // core clock
  input wire rst, // sync reset
  input wire cmd_we, // command strobe
  input wire [31:0] cmd_wdata, // command value
  input wire [31:0] cmd_rdata, // command readback
  input wire data_we, // data strobe
  input wire [31:0] data_wdata, // data value
  input wire [31:0] data_rdata, // data readback
  input wire duplex_full // duplex select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire busy = cmd_rdata[31];
  sequence s_start; cmd_we && cmd_wdata[31] && !busy; endsequence
  sequence s_pulse; busy ##[1:2] !busy; endsequence
  AST_BUSY_PULSE: assert property (s_start |=> s_pulse)
    else $error("busy did not pulse");
  AST_CMD_FIELDS: assert property (s_start |=> cmd_rdata[30] ==
    $past(cmd_wdata[30]) && cmd_rdata[7:0] == $past(cmd_wdata[7:0]))
    else $error("command fields not taken");
  AST_RSVD_ZERO: assert property (cmd_rdata[29:8] == 22'h0)
    else $error("reserved bits not zero");
  AST_NO_START: assert property (cmd_we && !cmd_wdata[31] && !busy |=> !busy)
    else $error("start without busy bit");
  AST_BUSY_REFUSE: assert property (busy && cmd_we |=> $stable(cmd_rdata[7:0]))
    else $error("command taken while busy");
  AST_DATA_WRITE: assert property (data_we && !busy && !cmd_we |=>
    data_rdata == $past(data_wdata))
    else $error("data write lost");
  AST_DATA_HOLD: assert property (!busy && !cmd_we && !data_we |=>
    $stable(data_rdata))
    else $error("data changed when idle");
  AST_RESET_CLEAR: assert property ($fell(rst) |-> cmd_rdata == 32'h0 &&
    data_rdata == 32'h0 && !duplex_full)
    else $error("outputs not cleared by reset");
endmodule // pia_phy_access_checker

/* pia_link_partner.sv */
// link partner: negotiation capability and ability word
`timescale 1ns/1ps
module pia_link_partner (
  input wire clk, // core clock
  input wire negotiates, // partner kind chosen by the bench
  input wire [15:0] ability_req, // abilities to advertise
  output reg partner_can_an = 1'b0, // partner negotiates
  output reg [15:0] partner_ability = 16'h0000 // partner ability word
);
  // answers a cycle late, as a slow partner would
  always @(posedge clk) begin
    partner_can_an <= negotiates;
    partner_ability <= negotiates ? ability_req : 16'h0000;
  end
endmodule // pia_link_partner

/* tb_phy_indirect_register_access.sv */
// self-checking bench for the phy access block
`timescale 1ns/1ps
module tb_phy_indirect_register_access;
  localparam [15:0] ID1 = 16'h2A5C; // arbitrary
  localparam [15:0] ID2 = 16'h3B6D; // arbitrary
  localparam AN_CYC = 200;
  logic clk = 0, rst = 1, cmd_we = 0, data_we = 0, strap = 0, neg = 1;
  logic [31:0] cmd_wdata = 0, data_wdata = 0, rd;
  wire [31:0] cmd_rdata, data_rdata;
  wire can_an, duplex_full;
  wire [15:0] ability;
  int num_errors = 0, n_tests = 0;
  logic [15:0] v;
  logic [4:0] pa;
  always #5 clk = ~clk;
  pia_phy_access #(.ID1_VAL(ID1), .ID2_VAL(ID2), .RST_CYCLES(20),
    .AN_CYCLES(AN_CYC)) dut_u (.clk(clk), .rst(rst), .cmd_we(cmd_we),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .data_we(data_we),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .speed_10_strap(strap),
    .partner_can_an(can_an), .partner_ability(ability),
    .duplex_full(duplex_full));
  pia_link_partner lp_u (.clk(clk), .negotiates(neg), .ability_req(16'h01E1),
    .partner_can_an(can_an), .partner_ability(ability));
  function automatic logic [15:0] id_exp(input logic [4:0] p, x);
    return (p != 5'd1) ? 16'hFFFF : ((x == 5'd2) ? ID1 : ID2);
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mac(input logic rdn, input logic [7:0] a, input logic [31:0] d);
    int i;
    if (!rdn) begin
      data_we = 1;
      data_wdata = d;
      tick(1);
      data_we = 0;
    end
    cmd_we = 1;
    cmd_wdata = {1'b1, rdn, 22'($urandom), a};
    tick(1);
    cmd_we = 0;
    for (i = 0; i < 8 && cmd_rdata[31] !== 1'b0; i++) tick(1);
    chk(cmd_rdata, {1'b0, rdn, 22'h0, a}, "cmd readback");
    rd = data_rdata;
  endtask
  task automatic phy(input logic w, input logic [4:0] p, x, input logic [15:0] d);
    if (w) mac(0, 8'h07, {16'h0, d});
    mac(0, 8'h06, {16'h0, p, x, 4'h0, w, 1'b1});
    for (int i = 0; i < 8; i++) begin
      mac(1, 8'h06, 0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 0, "phy busy");
    mac(1, 8'h07, 0);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(58));
    tick(12);
    rst = 0;
    tick(1);
    chk(data_rdata, 0, "reset data");
    for (int k = 0; k < 4; k++) begin
      pa = k[0] ? 5'd1 : (k == 0 ? 5'd0 : 5'($urandom_range(31, 2)));
      phy(0, pa, 5'(2 + k / 2), 0);
      chk(rd, {16'h0, id_exp(pa, 5'(2 + k / 2))}, "phy id");
    end
    $display("test presence done");
    v = 16'($urandom);
    phy(1, 5'd1, 5'h04, v);
    phy(0, 5'd1, 5'h04, 0);
    chk(rd, {16'h0, v}, "phy write read");
    mac(0, 8'h01, 32'h0010_0000);
    chk(duplex_full, 1, "duplex");
    mac(1, 8'h01, 0);
    chk(rd[20], 1, "duplex readback");
    $display("test access done");
    phy(1, 5'd1, 5'h04, 16'h01E1);
    phy(1, 5'd1, 5'h00, 16'h1200);
    tick(AN_CYC);
    phy(0, 5'd1, 5'h01, 0);
    chk(rd[5], 1, "negotiation done");
    phy(0, 5'd1, 5'h05, 0);
    chk(rd, 32'h01E1, "partner ability");
    phy(1, 5'd1, 5'h00, 16'h8000);
    tick(20);
    phy(0, 5'd1, 5'h00, 0);
    chk(rd, 32'h3000, "phy reset");
    $display("test negotiation done");
    for (int s = 1; s >= 0; s--) begin
      strap = s[0];
      neg = 0;
      rst = 1;
      tick(2);
      rst = 0;
      tick(1);
      phy(0, 5'd1, 5'h00, 0);
      chk(rd, strap ? 32'h0 : 32'h3000, "strap default");
    end
    tick(AN_CYC);
    phy(0, 5'd1, 5'h00, 0);
    chk(rd, 32'h2000, "fallback");
    $display("test strap done");
    complete_run();
  end
endmodule // tb_phy_indirect_register_access
bind pia_phy_access pia_phy_access_checker chk_u (.clk(clk), .rst(rst),
  .cmd_we(cmd_we), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .data_we(data_we), .data_wdata(data_wdata), .data_rdata(data_rdata),
  .duplex_full(duplex_full));
